/* File: hdl/spc_phase_counter.sv */
// stepper phase counter with step pin, resolution select and pwm alignment
`timescale 1ns/10ps
`include "spc_defs.svh"
//
// Operation
// - enable low: standby, all state default
// - active only after start-up delay
// - cycle has 64/32/16/8/4 positions
// - one index source chosen by step select
// - index changes applied at next pwm period
// - pin mode: spi writes to index ignored
// - pin edge steps index by direction
// - step size 1,2,4,8,16 per resolution code
// - function select 1: pin picks resolution
// - finer to coarser snaps index to nearest
// - snapping applied after next counter command
// - spi mode: step pin ignored
// - spi mode: resolution sets full step and snapping
// - resolution change waits for next update
// - index gives coil signs and table entry
// - stall auto hold freezes the index
module spc_phase_counter (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic enable_pin,
	input wire spc_pkg::spc_cfg_t cfg,
	input wire logic spi_wr_valid,
	input wire logic [5:0] spi_wr_index,
	input wire logic step_clock_pin,
	input wire logic resolution_select_pin,
	input wire logic pwm_period_start,
	input wire logic stall_flag,
	input wire logic stall_auto_hold,
	input wire logic hold_request,
	output logic active,
	output logic [5:0] angle_index,
	output logic [5:0] applied_index,
	output logic sign_a,
	output logic sign_b,
	output logic [4:0] table_sel,
	output logic full_step
);
	spc_pkg::spc_state_all_t s_r;
	spc_pkg::spc_state_all_t s_nxt;
	logic step_rise;

	// step count per pin edge
	function automatic logic [5:0] step_size(input logic [2:0] res);
		case (res)
			`SPC_RES_SIXTEENTH: step_size = `SPC_STEP_1;
			`SPC_RES_EIGHTH: step_size = `SPC_STEP_2;
			`SPC_RES_MINI: step_size = `SPC_STEP_4;
			`SPC_RES_HALF: step_size = `SPC_STEP_8;
			default: step_size = `SPC_STEP_16;
		endcase
	endfunction

	// snap to nearest multiple of step, halfway rounds up, wraps mod 64
	function automatic logic [5:0] snap(input logic [5:0] idx, input logic [5:0] stp);
		logic [5:0] mask;
		mask = ~(stp - 6'h01);
		snap = (idx + (stp >> 1)) & mask;
	endfunction

	spc_edge_detect u_edge (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.pin_in(step_clock_pin),
		.rise(step_rise)
	);

	logic [2:0] res_sel;
	logic frozen;
	logic cmd;
	logic [5:0] stp;
	logic [5:0] idx_eff;
	logic [4:0] q;

	always_comb begin
		s_nxt = s_r;
		// pin chooses between primary and alternate only in this function
		res_sel = (cfg.resolution_select_pin_function_select == `SPC_FUNC_RES_PIN && resolution_select_pin) ?
			cfg.alternate_step_resolution : cfg.primary_step_resolution;
		frozen = hold_request & stall_flag & stall_auto_hold;
		cmd = 1'b0;
		stp = step_size(s_r.res_act);
		idx_eff = s_r.applied_index;
		q = 5'h00;
		case (s_r.state)
			spc_pkg::SPC_ST_STANDBY: begin
				s_nxt.state = spc_pkg::SPC_ST_START;
				s_nxt.start_cnt = 14'h0000;
			end
			spc_pkg::SPC_ST_START: begin
				// outputs stay off until the start-up delay runs out
				if (s_r.start_cnt == 14'(`SPC_START_CYC - 1)) begin
					s_nxt.state = spc_pkg::SPC_ST_ACTIVE;
					s_nxt.active = 1'b1;
				end else begin
					s_nxt.start_cnt = s_r.start_cnt + 14'h0001;
				end
			end
			spc_pkg::SPC_ST_ACTIVE: begin
				s_nxt.res_pend = res_sel;
				if (cfg.step_clock_pin_step_select) begin
					// spi writes dropped, pin edges step
					if (step_rise && !frozen) begin
						cmd = 1'b1;
						if (cfg.direction) begin
							s_nxt.angle_index = s_r.angle_index + stp;
						end else begin
							s_nxt.angle_index = s_r.angle_index - stp;
						end
					end
				end else begin
					// host supplies every value; pin is ignored
					if (spi_wr_valid && !frozen) begin
						cmd = 1'b1;
						s_nxt.angle_index = spi_wr_index;
					end
				end
				if (cmd) begin
					s_nxt.upd_pend = 1'b1;
				end
				// index and resolution changes land at period start
				if (pwm_period_start && (s_r.upd_pend || cmd)) begin
					s_nxt.upd_pend = 1'b0;
					s_nxt.res_act = s_r.res_pend;
					if (step_size(s_r.res_pend) > step_size(s_r.res_act)) begin
						// coarser: snap deferred until this period
						s_nxt.applied_index = snap(s_nxt.angle_index, step_size(s_r.res_pend));
						s_nxt.angle_index = s_nxt.applied_index;
					end else begin
						s_nxt.applied_index = s_nxt.angle_index;
					end
				end
				idx_eff = s_nxt.applied_index;
			end
			default: begin
				s_nxt.state = spc_pkg::SPC_ST_STANDBY;
			end
		endcase
		// 64 positions, quadrant from top bits, entry 0..16
		q = idx_eff[4] ? (5'h10 - {1'b0, idx_eff[3:0]}) : {1'b0, idx_eff[3:0]};
		s_nxt.table_sel = q;
		s_nxt.sign_a = idx_eff[5] ^ (idx_eff[4] & (idx_eff[3:0] != 4'h0));
		s_nxt.sign_b = idx_eff[5];
		// in spi mode resolution sets full step and the snap of the written index
		s_nxt.full_step = (s_nxt.res_act != `SPC_RES_SIXTEENTH) &&
			(s_nxt.res_act != `SPC_RES_EIGHTH) && (s_nxt.res_act != `SPC_RES_MINI) &&
			(s_nxt.res_act != `SPC_RES_HALF);
	end

	always_ff @(posedge clk_sys) begin
		// enable low holds everything at default
		if (!rst_n || !enable_pin) begin
			s_r <= '{state: spc_pkg::SPC_ST_STANDBY, start_cnt: 14'h0000,
				angle_index: `SPC_PH_RST, res_pend: 3'h0, res_act: 3'h0,
				upd_pend: 1'b0, applied_index: `SPC_PH_RST, sign_a: 1'b0,
				sign_b: 1'b0, table_sel: 5'h00, full_step: 1'b0, active: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign active = s_r.active;
	assign angle_index = s_r.angle_index;
	assign applied_index = s_r.applied_index;
	assign sign_a = s_r.sign_a;
	assign sign_b = s_r.sign_b;
	assign table_sel = s_r.table_sel;
	assign full_step = s_r.full_step;
endmodule

/* File: shared/spc_defs.svh */
// constants for the stepper phase counter block
`ifndef SPC_DEFS_SVH
`define SPC_DEFS_SVH
`define SPC_CLK_HZ 25000000
`define SPC_T_START_US 200
`define SPC_START_CYC ((`SPC_T_START_US * (`SPC_CLK_HZ / 1000000)))
`define SPC_PH_RST 6'h00
`define SPC_RES_SIXTEENTH 3'h0
`define SPC_RES_EIGHTH 3'h1
`define SPC_RES_MINI 3'h2
`define SPC_RES_HALF 3'h4
`define SPC_FUNC_RES_PIN 2'h1
`define SPC_STEP_1 6'h01
`define SPC_STEP_2 6'h02
`define SPC_STEP_4 6'h04
`define SPC_STEP_8 6'h08
`define SPC_STEP_16 6'h10
`endif

/* File: shared/spc_pkg.sv */
// types for the stepper phase counter block
package spc_pkg;
	typedef enum logic [2:0] {
		SPC_ST_STANDBY = 3'b001,
		SPC_ST_START = 3'b010,
		SPC_ST_ACTIVE = 3'b100
	} spc_state_t;
	typedef struct packed {
		logic step_clock_pin_step_select;
		logic [1:0] resolution_select_pin_function_select;
		logic [2:0] primary_step_resolution;
		logic [2:0] alternate_step_resolution;
		logic direction;
	} spc_cfg_t;
	typedef struct packed {
		logic sync1;
		logic sync2;
		logic prev;
		logic rise;
	} spc_edge_t;
	typedef struct packed {
		spc_state_t state;
		logic [13:0] start_cnt;
		logic [5:0] angle_index;
		logic [2:0] res_pend;
		logic [2:0] res_act;
		logic upd_pend;
		logic [5:0] applied_index;
		logic sign_a;
		logic sign_b;
		logic [4:0] table_sel;
		logic full_step;
		logic active;
	} spc_state_all_t;
endpackage

/* File: hdl/spc_edge_detect.sv */
// step clock pin synchroniser and rising edge detector
`timescale 1ns/10ps
module spc_edge_detect (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic pin_in,
	output logic rise
);
	spc_pkg::spc_edge_t s_r;
	spc_pkg::spc_edge_t s_nxt;
	always_comb begin
		s_nxt = s_r;
		s_nxt.sync1 = pin_in;
		s_nxt.sync2 = s_r.sync1;
		s_nxt.prev = s_r.sync2;
		// one pulse per edge, seen only after two flops
		s_nxt.rise = s_r.sync2 & ~s_r.prev;
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
	assign rise = s_r.rise;
endmodule

/* File: dv/spc_phase_monitor.sv */
// port assertions for the phase counter
`timescale 1ns/10ps
module spc_phase_monitor (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic enable_pin,
	input wire spc_pkg::spc_cfg_t cfg,
	input wire logic spi_wr_valid,
	input wire logic [5:0] spi_wr_index,
	input wire logic step_clock_pin,
	input wire logic pwm_period_start,
	input wire logic stall_flag,
	input wire logic stall_auto_hold,
	input wire logic hold_request,
	input wire logic active,
	input wire logic [5:0] angle_index,
	input wire logic [5:0] applied_index,
	input wire logic full_step
);
	logic [13:0] en_cnt_r;
	logic [5:0] wr_r;
	logic [3:0] pw_r;
	wire logic frz = stall_flag && stall_auto_hold && hold_request;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// saturating count of cycles since enable rose
	always_ff @(posedge clk_sys) begin
		en_cnt_r <= (!rst_n || !enable_pin) ? 14'h0000 : en_cnt_r + {13'h0000, en_cnt_r != 14'h3FFF};
		pw_r <= {pw_r[2:0], pwm_period_start};
		if (spi_wr_valid) begin
			wr_r <= spi_wr_index;
		end
	end
	a_standby_clear: assert property (!enable_pin |=> !active && angle_index == 6'h00)
		else $error("standby state kept");
	a_start_delay: assert property (active |-> en_cnt_r >= 14'h1388)
		else $error("active too early");
	a_spi_write: assert property (active && !cfg.step_clock_pin_step_select && spi_wr_valid && !frz
		|=> ##[0:1] angle_index == wr_r) else $error("spi write lost");
	// enable low clears the index on purpose, so the hold checks need it high
	a_spi_hold: assert property ((enable_pin && !cfg.step_clock_pin_step_select && !spi_wr_valid
		&& !pwm_period_start)[*3] |=> $stable(angle_index)) else $error("index moved");
	a_pin_hold: assert property ((enable_pin && cfg.step_clock_pin_step_select && !step_clock_pin
		&& !pwm_period_start)[*4] |=> $stable(angle_index)) else $error("index moved");
	a_stall_freeze: assert property ((enable_pin && frz) [*2] |=> $stable(angle_index))
		else $error("frozen index moved");
	a_apply_pwm: assert property (enable_pin && $changed(applied_index) |-> |pw_r)
		else $error("applied off period");
	a_profile_pwm: assert property (enable_pin && $changed(full_step) |-> |pw_r)
		else $error("mode off period");
endmodule
bind spc_phase_counter spc_phase_monitor u_spc_phase_monitor (.*);

/* File: dv/spc_host_model.sv */
// host step pulse source
`timescale 1ns/10ps
module spc_host_model (
	input wire logic clk_sys,
	input wire logic go,
	output logic step_clock_pin
);
	logic [2:0] cnt_r = 3'h0;
	always @(posedge clk_sys) begin
		cnt_r <= (go && cnt_r == 3'h0) ? 3'h6 : cnt_r - {2'h0, cnt_r != 3'h0};
	end
	// three high then four low: one clean edge per pulse
	assign step_clock_pin = cnt_r > 3'h3;
endmodule

/* File: dv/tb_top.sv */
// self-checking bench for the phase counter
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
	logic clk_sys = 1'b0, rst_n = 1'b0, en = 1'b0, wv = 1'b0, pwm = 1'b0;
	logic rsel = 1'b0, go = 1'b0, frz = 1'b0, pin, act, sa, sb, fs;
	logic [4:0] ts;
	logic [5:0] wi = 6'h00, ang, app, a;
	spc_pkg::spc_cfg_t cfg = '0;
	int n_mismatch = 0, tests_run = 0, i;
	localparam logic [2:0] RES [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7};
	localparam logic [5:0] STP [5] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10};
	always #20 clk_sys = ~clk_sys;
	spc_phase_counter u_spc_phase_counter (.clk_sys(clk_sys), .rst_n(rst_n), .enable_pin(en),
		.cfg(cfg), .spi_wr_valid(wv), .spi_wr_index(wi), .step_clock_pin(pin),
		.resolution_select_pin(rsel), .pwm_period_start(pwm), .stall_flag(frz),
		.stall_auto_hold(frz), .hold_request(frz), .active(act), .angle_index(ang),
		.applied_index(app), .sign_a(sa), .sign_b(sb), .table_sel(ts), .full_step(fs));
	spc_host_model u_spc_host_model (.clk_sys(clk_sys), .go(go), .step_clock_pin(pin));
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic pulse(ref logic s, input int n);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
		cyc(n);
	endtask
	task automatic spi_wr(input logic [5:0] v);
		wi = v;
		pulse(wv, 3);
	endtask
	task automatic done(input int t);
		$display("test %0d done", t);
	endtask
	task automatic end_of_test;
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		cyc(9000);
		n_mismatch++;
		end_of_test;
	end
	initial begin
		cyc(20);
		rst_n = 1'b1;
		en = 1'b1;
		`CHK(ang, 6'h00);
		cyc(4990);
		`CHK(act, 1'b0);
		for (i = 0; i < 100 && act !== 1'b1; i++) cyc(1);
		`CHK(act, 1'b1);
		done(1);
		spi_wr(6'h2A);
		`CHK(ang, 6'h2A);
		`CHK(app, 6'h00);
		pulse(pwm, 4);
		`CHK(app, 6'h2A);
		`CHK(ts, 5'h0A);
		`CHK(sa, 1'b1);
		`CHK(sb, 1'b1);
		`CHK(fs, 1'b0);
		pulse(go, 10);
		`CHK(ang, 6'h2A);
		done(2);
		cfg.step_clock_pin_step_select = 1'b1;
		cfg.direction = 1'b1;
		spi_wr(6'h00);
		`CHK(ang, 6'h2A);
		// one command plus a period lets each new mode and its snap land first
		for (i = 0; i < 5; i++) begin
			cfg.primary_step_resolution = RES[i];
			pulse(go, 10);
			pulse(pwm, 4);
			`CHK(fs, (i == 4));
			a = ang;
			pulse(go, 10);
			`CHK(ang, 6'(a + STP[i]));
		end
		cfg.direction = 1'b0;
		for (i = 0; i < 5; i++) begin
			a = ang;
			pulse(go, 10);
			`CHK(ang, 6'(a - 6'h10));
		end
		done(3);
		cfg.resolution_select_pin_function_select = 2'h1;
		rsel = 1'b1;
		pulse(go, 10);
		pulse(pwm, 4);
		a = ang;
		pulse(go, 10);
		`CHK(ang, 6'(a - 6'h01));
		frz = 1'b1;
		pulse(go, 10);
		`CHK(ang, 6'(a - 6'h01));
		done(4);
		en = 1'b0;
		cyc(2);
		`CHK(act, 1'b0);
		`CHK(ang, 6'h00);
		`CHK(app, 6'h00);
		done(5);
		end_of_test;
	end
endmodule
